//--- pkg/cfsup_pkg.sv
// Constants and carrier types for the charger fault supervisor.
package cfsup_pkg;

	// ==========================================================
	// Clock and time base
	localparam int CLK_MHZ = 100;
	localparam int TICK_US = 100; // Slow time base for protection timers
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

	// ==========================================================
	// Timer figures in their own units, and derived tick counts
	localparam int WD_SHORT_S = 44;
	localparam int WD_MID_S = 88;
	localparam int WD_LONG_S = 175;
	localparam int WD_SHORT_TICKS = WD_SHORT_S * (1000000 / TICK_US);
	localparam int WD_MID_TICKS = WD_MID_S * (1000000 / TICK_US);
	localparam int WD_LONG_TICKS = WD_LONG_S * (1000000 / TICK_US);
	localparam int INPUT_OVERCURRENT_LATCH_BLANK_US = 4200;
	localparam int INPUT_OVERCURRENT_LATCH_BLANK_TICKS = INPUT_OVERCURRENT_LATCH_BLANK_US / TICK_US;
	localparam int OVP_LIMIT_US = 30000;
	localparam int OVP_LIMIT_TICKS = OVP_LIMIT_US / TICK_US;
	localparam int BATLOW_RESET_US = 1000;
	localparam int BATLOW_RESET_TICKS = BATLOW_RESET_US / TICK_US;
	localparam int BATLOW_RESTART_US = 4000; // Least of the 4-5 ms window
	localparam int BATLOW_RESTART_TICKS = (BATLOW_RESTART_US + TICK_US - 1) / TICK_US;
	localparam int SS_STEP_US = 240;
	localparam int SS_STEP_CYCLES = SS_STEP_US * CLK_MHZ;
	localparam int DEAD_NS = 30;
	localparam int DEAD_CYCLES = (DEAD_NS * CLK_MHZ + 999) / 1000;
	localparam int REFRESH_NS = 100;
	localparam int REFRESH_CYCLES = (REFRESH_NS * CLK_MHZ + 999) / 1000;
	localparam int TMR_W = 21;
	localparam int SW_CNT_W = 4;

	// ==========================================================
	// Option word layout
	localparam int OPT_INHIBIT_BIT = 0;
	localparam int OPT_INPUT_OVERCURRENT_LATCH_EN_BIT = 1;
	localparam int OPT_WD_LO = 13;
	localparam int OPT_WD_HI = 14;
	localparam logic [15:0] OPT_RESET = 16'h6002; // Watchdog long, input latch on
	localparam logic [1:0] WD_OFF = 2'h0;
	localparam logic [1:0] WD_SHORT = 2'h1;
	localparam logic [1:0] WD_MID = 2'h2;
	localparam logic [1:0] WD_LONG = 2'h3;

	// ==========================================================
	// Charge current figures in mA
	localparam logic [12:0] SS_START_MA = 13'h0080;
	localparam logic [12:0] SS_STEP_MA = 13'h0040;
	localparam logic [12:0] BATLOW_CAP_MA = 13'h01F4;
	localparam logic [12:0] PEAK_BAND1_MA = 13'h0BB8; // Below this the 6 A limit
	localparam logic [12:0] PEAK_BAND2_MA = 13'h1194; // Below this the 9 A limit
	localparam logic [1:0] PEAK_6A = 2'h0;
	localparam logic [1:0] PEAK_9A = 2'h1;
	localparam logic [1:0] PEAK_12A = 2'h2;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic batOverVoltage;  // Above 104 % of set-point
		logic batLow;          // Below 2.5 V
		logic avgCurrentLow;   // Average below 125 mA
		logic avgCurrentHigh;  // Average above 250 mA
		logic underCurrent;    // Sense below 5 mV
		logic peakOverCurrent; // Above selected peak limit
		logic bootstrapLow;    // Bootstrap below 4.3 V
		logic dieHot;          // Above 155 C
		logic dieCool;         // Below 135 C
		logic sysOverCurrent;  // Above 3.33x input limit
	} cfsup_flags_t;

	typedef struct packed {
		logic watchdogExpired;
		logic inputLatched;
		logic overVoltage;
		logic overVoltageOff;
		logic batteryLow;
		logic thermalStop;
		logic nonSync;
		logic charging;
	} cfsup_status_t;

	typedef enum logic [2:0] {
		SW_IDLE = 3'b000,
		SW_DEAD_HS = 3'b001,
		SW_HIGH = 3'b010,
		SW_DEAD_LS = 3'b011,
		SW_LOW = 3'b100
	} cfsup_sw_t;

	typedef enum logic [1:0] {
		BL_NORMAL = 2'b00,
		BL_LIMIT = 2'b01,
		BL_RESET = 2'b10
	} cfsup_bl_t;

endpackage : cfsup_pkg

//--- src/cfsup_top.sv
// Charger fault supervisor: watchdog, switch sequencing and protections.
`timescale 1ns/1ns
module cfsup_top import cfsup_pkg::*; #(
	parameter int TICK_LEN = TICK_CYCLES,
	parameter int WD_SHORT_LEN = WD_SHORT_TICKS,
	parameter int WD_MID_LEN = WD_MID_TICKS,
	parameter int WD_LONG_LEN = WD_LONG_TICKS,
	parameter int SS_STEP_LEN = SS_STEP_CYCLES,
	parameter logic [12:0] PEAK_BAND1 = PEAK_BAND1_MA,
	parameter logic [12:0] PEAK_BAND2 = PEAK_BAND2_MA
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Host writes
	input wire logic voltageLimitWrite,
	input wire logic [15:0] voltageLimitValue,
	input wire logic currentLimitWrite,
	input wire logic [12:0] currentLimitValue,
	input wire logic optionWrite,
	input wire logic [15:0] optionWordIn,
	// Converter inputs
	input wire logic cycleStart,
	input wire logic errorAboveRamp,
	input wire logic adapterPresent,
	input wire cfsup_flags_t flagsIn,
	// Switch and protection outputs
	output logic highSideSwitch,
	output logic lowSideSwitch,
	output logic inputPowerSwitch,
	output logic dischargeSink,
	output logic [1:0] peakLimitSel,
	output logic [12:0] currentTarget,
	// Status
	output logic [15:0] voltageLimitReg,
	output logic [12:0] currentLimitReg,
	output logic [15:0] optionWordReg,
	output cfsup_status_t status
);

	// ==========================================================
	// Flag synchroniser
	cfsup_flags_t syncA_reg, flags;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			syncA_reg <= '0;
			flags <= '0;
		end else begin
			syncA_reg <= flagsIn;
			flags <= syncA_reg;
		end
	end

	// ==========================================================
	// Protection and timer state
	logic [15:0] vlim_reg, vlim_next;
	logic [12:0] ilim_reg, ilim_next;
	logic [15:0] opt_reg, opt_next;
	logic [13:0] tickCnt_reg, tickCnt_next;
	logic tick;
	logic [TMR_W-1:0] wdCnt_reg, wdCnt_next;
	logic wdExp_reg, wdExp_next;
	logic [TMR_W-1:0] acocCnt_reg, acocCnt_next;
	logic acocLatch_reg, acocLatch_next;
	logic [TMR_W-1:0] ovpCnt_reg, ovpCnt_next;
	logic ovpOff_reg, ovpOff_next;
	cfsup_bl_t bl_reg, bl_next;
	logic [TMR_W-1:0] blCnt_reg, blCnt_next;
	logic therm_reg, therm_next;
	logic nonSync_reg, nonSync_next;
	logic [12:0] target_reg, target_next;
	logic [14:0] ssCnt_reg, ssCnt_next;
	logic run_reg;
	logic ovpActive, chargeRun, limitWrite;
	logic [1:0] wdSel;
	logic [TMR_W-1:0] wdLimit;
	logic [12:0] cap;

	assign tick = (tickCnt_reg == 14'(TICK_LEN - 1));
	assign limitWrite = voltageLimitWrite | currentLimitWrite;
	assign wdSel = opt_reg[OPT_WD_HI:OPT_WD_LO];
	assign ovpActive = flags.batOverVoltage && (vlim_reg != 16'h0000);
	// Battery-low cap never lifts a programmed limit that is already lower
	assign cap = (bl_reg != BL_NORMAL && ilim_reg > BATLOW_CAP_MA) ? BATLOW_CAP_MA : ilim_reg;

	// Every condition that must hold for the converter to run
	assign chargeRun = !opt_reg[OPT_INHIBIT_BIT] && !wdExp_reg && !ovpOff_reg
		&& !acocLatch_reg && !therm_reg && (bl_reg != BL_RESET)
		&& (vlim_reg != 16'h0000) && (ilim_reg != 13'h0000) && adapterPresent;

	always_comb begin
		unique case (wdSel)
			WD_SHORT: wdLimit = TMR_W'(WD_SHORT_LEN);
			WD_MID: wdLimit = TMR_W'(WD_MID_LEN);
			WD_LONG: wdLimit = TMR_W'(WD_LONG_LEN);
			WD_OFF: wdLimit = '0;
		endcase
	end

	// Next values of all protection state
	always_comb begin
		vlim_next = voltageLimitWrite ? voltageLimitValue : vlim_reg;
		ilim_next = currentLimitWrite ? currentLimitValue : ilim_reg;
		opt_next = optionWrite ? optionWordIn : opt_reg;
		tickCnt_next = tick ? 14'h0000 : tickCnt_reg + 14'h0001;
		// Watchdog: registers untouched on expiry, only charging stops
		wdCnt_next = wdCnt_reg;
		wdExp_next = wdExp_reg;
		if (limitWrite) begin
			wdCnt_next = '0;
			wdExp_next = 1'b0;
		end else if (optionWrite && optionWordIn[OPT_WD_HI:OPT_WD_LO] == WD_OFF) begin
			wdCnt_next = '0;
			wdExp_next = 1'b0;
		end else if (wdSel != WD_OFF && tick && !wdExp_reg) begin
			if (wdCnt_reg >= wdLimit - TMR_W'(1)) begin
				wdExp_next = 1'b1;
			end else begin
				wdCnt_next = wdCnt_reg + TMR_W'(1);
			end
		end
		// Input over-current: blanked, then latched until adapter gone
		acocCnt_next = flags.sysOverCurrent ? acocCnt_reg : '0;
		acocLatch_next = acocLatch_reg;
		if (flags.sysOverCurrent && opt_reg[OPT_INPUT_OVERCURRENT_LATCH_EN_BIT] && tick) begin
			if (acocCnt_reg >= TMR_W'(INPUT_OVERCURRENT_LATCH_BLANK_TICKS - 1)) begin
				acocLatch_next = 1'b1;
			end else begin
				acocCnt_next = acocCnt_reg + TMR_W'(1);
			end
		end
		if (!adapterPresent) begin
			acocLatch_next = 1'b0;
		end
		// Over-voltage persistence turns charging off until the adapter is removed
		ovpCnt_next = ovpActive ? ovpCnt_reg : '0;
		ovpOff_next = ovpOff_reg;
		if (ovpActive && tick) begin
			if (ovpCnt_reg >= TMR_W'(OVP_LIMIT_TICKS - 1)) begin
				ovpOff_next = 1'b1;
			end else begin
				ovpCnt_next = ovpCnt_reg + TMR_W'(1);
			end
		end
		if (!adapterPresent) begin
			ovpOff_next = 1'b0;
		end
		// Battery low sequence: limit, reset, wait, restart
		bl_next = bl_reg;
		blCnt_next = blCnt_reg;
		unique case (bl_reg)
			BL_NORMAL: begin
				blCnt_next = '0;
				if (flags.batLow) begin
					bl_next = BL_LIMIT;
				end
			end
			BL_LIMIT: begin
				if (!flags.batLow) begin
					bl_next = BL_NORMAL;
				end else if (tick) begin
					if (blCnt_reg >= TMR_W'(BATLOW_RESET_TICKS - 1)) begin
						bl_next = BL_RESET;
						blCnt_next = '0;
					end else begin
						blCnt_next = blCnt_reg + TMR_W'(1);
					end
				end
			end
			BL_RESET: begin
				if (tick) begin
					if (blCnt_reg >= TMR_W'(BATLOW_RESTART_TICKS - 1)) begin
						bl_next = flags.batLow ? BL_LIMIT : BL_NORMAL;
						blCnt_next = '0;
					end else begin
						blCnt_next = blCnt_reg + TMR_W'(1);
					end
				end
			end
			default: begin
				bl_next = BL_NORMAL;
				blCnt_next = '0;
			end
		endcase
		// Thermal hysteresis
		therm_next = therm_reg;
		if (flags.dieHot) begin
			therm_next = 1'b1;
		end else if (flags.dieCool) begin
			therm_next = 1'b0;
		end
		// Synchronous / non-synchronous hysteresis
		nonSync_next = nonSync_reg;
		if (flags.avgCurrentLow || flags.batLow) begin
			nonSync_next = 1'b1;
		end else if (flags.avgCurrentHigh) begin
			nonSync_next = 1'b0;
		end
		// Soft-start ramps the target every time charging starts
		target_next = target_reg;
		ssCnt_next = ssCnt_reg;
		if (!chargeRun) begin
			target_next = '0;
			ssCnt_next = '0;
		end else if (!run_reg) begin
			target_next = (SS_START_MA < cap) ? SS_START_MA : cap;
			ssCnt_next = '0;
		end else if (target_reg > cap) begin
			target_next = cap;
		end else if (ssCnt_reg >= 15'(SS_STEP_LEN - 1)) begin
			ssCnt_next = '0;
			target_next = (cap - target_reg > SS_STEP_MA) ? target_reg + SS_STEP_MA : cap;
		end else begin
			ssCnt_next = ssCnt_reg + 15'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			vlim_reg <= '0;
			ilim_reg <= '0;
			opt_reg <= OPT_RESET;
			tickCnt_reg <= '0;
			wdCnt_reg <= '0;
			wdExp_reg <= 1'b0;
			acocCnt_reg <= '0;
			acocLatch_reg <= 1'b0;
			ovpCnt_reg <= '0;
			ovpOff_reg <= 1'b0;
			bl_reg <= BL_NORMAL;
			blCnt_reg <= '0;
			therm_reg <= 1'b0;
			nonSync_reg <= 1'b0;
			target_reg <= '0;
			ssCnt_reg <= '0;
			run_reg <= 1'b0;
		end else begin
			vlim_reg <= vlim_next;
			ilim_reg <= ilim_next;
			opt_reg <= opt_next;
			tickCnt_reg <= tickCnt_next;
			wdCnt_reg <= wdCnt_next;
			wdExp_reg <= wdExp_next;
			acocCnt_reg <= acocCnt_next;
			acocLatch_reg <= acocLatch_next;
			ovpCnt_reg <= ovpCnt_next;
			ovpOff_reg <= ovpOff_next;
			bl_reg <= bl_next;
			blCnt_reg <= blCnt_next;
			therm_reg <= therm_next;
			nonSync_reg <= nonSync_next;
			target_reg <= target_next;
			ssCnt_reg <= ssCnt_next;
			run_reg <= chargeRun;
		end
	end

	// ==========================================================
	// Switch sequencer
	cfsup_sw_t sw_reg, sw_next;
	logic [SW_CNT_W-1:0] swCnt_reg, swCnt_next;
	logic ocp_reg, ocp_next;
	logic refresh_reg, refresh_next;
	logic lowAllowed, blockAll;

	// Over-voltage and a stopped converter block both switches
	assign blockAll = ovpActive || !run_reg;
	assign lowAllowed = !nonSync_reg && (bl_reg == BL_NORMAL);

	always_comb begin
		sw_next = sw_reg;
		swCnt_next = swCnt_reg;
		refresh_next = refresh_reg;
		// Set beats the cycle-start clear so a late trip is not lost
		ocp_next = flags.peakOverCurrent ? 1'b1 : (cycleStart ? 1'b0 : ocp_reg);
		unique case (sw_reg)
			SW_IDLE: begin
				swCnt_next = '0;
				refresh_next = 1'b0;
				if (!blockAll && flags.bootstrapLow) begin
					sw_next = SW_LOW;
					refresh_next = 1'b1;
				end else if (!blockAll && cycleStart && errorAboveRamp
						&& !flags.peakOverCurrent) begin
					sw_next = SW_DEAD_HS;
				end
			end
			SW_DEAD_HS: begin
				swCnt_next = swCnt_reg + SW_CNT_W'(1);
				if (blockAll || ocp_reg || !errorAboveRamp) begin
					sw_next = SW_IDLE;
				end else if (swCnt_reg >= SW_CNT_W'(DEAD_CYCLES - 1)) begin
					sw_next = SW_HIGH;
				end
			end
			SW_HIGH: begin
				swCnt_next = '0;
				if (blockAll || ocp_reg || flags.peakOverCurrent || !errorAboveRamp
						|| flags.bootstrapLow) begin
					sw_next = SW_DEAD_LS;
					refresh_next = flags.bootstrapLow;
				end
			end
			SW_DEAD_LS: begin
				swCnt_next = swCnt_reg + SW_CNT_W'(1);
				if (swCnt_reg >= SW_CNT_W'(DEAD_CYCLES - 1)) begin
					swCnt_next = '0;
					if (!blockAll && (lowAllowed || refresh_reg)) begin
						sw_next = SW_LOW;
					end else begin
						sw_next = SW_IDLE;
					end
				end
			end
			SW_LOW: begin
				swCnt_next = swCnt_reg + SW_CNT_W'(1);
				if (blockAll) begin
					sw_next = SW_IDLE;
				end else if (refresh_reg) begin
					if (swCnt_reg >= SW_CNT_W'(REFRESH_CYCLES - 1)) begin
						sw_next = SW_IDLE;
						swCnt_next = '0;
					end
				end else if (cycleStart) begin
					sw_next = SW_DEAD_HS;
					swCnt_next = '0;
				end else if (flags.underCurrent || !lowAllowed) begin
					sw_next = SW_IDLE;
				end
			end
			default: sw_next = SW_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_reg <= SW_IDLE;
			swCnt_reg <= '0;
			ocp_reg <= 1'b0;
			refresh_reg <= 1'b0;
		end else begin
			sw_reg <= sw_next;
			swCnt_reg <= swCnt_next;
			ocp_reg <= ocp_next;
			refresh_reg <= refresh_next;
		end
	end

	// ==========================================================
	// Outputs
	always_comb begin
		if (ilim_reg < PEAK_BAND1) begin
			peakLimitSel = PEAK_6A;
		end else if (ilim_reg < PEAK_BAND2) begin
			peakLimitSel = PEAK_9A;
		end else begin
			peakLimitSel = PEAK_12A;
		end
	end

	// Switch drives decode straight from the state, so never both on
	assign highSideSwitch = (sw_reg == SW_HIGH);
	assign lowSideSwitch = (sw_reg == SW_LOW);
	assign inputPowerSwitch = adapterPresent && !acocLatch_reg;
	assign dischargeSink = ovpActive;
	assign currentTarget = target_reg;
	assign voltageLimitReg = vlim_reg;
	assign currentLimitReg = ilim_reg;
	assign optionWordReg = opt_reg;
	assign status = '{watchdogExpired: wdExp_reg, inputLatched: acocLatch_reg,
		overVoltage: ovpActive, overVoltageOff: ovpOff_reg,
		batteryLow: (bl_reg != BL_NORMAL), thermalStop: therm_reg,
		nonSync: nonSync_reg, charging: run_reg};

endmodule : cfsup_top

//--- bench/cfsup_host.sv
// Host controller model that issues limit and option writes.
`timescale 1ns/1ns
module cfsup_host (
	// Clock
	input wire logic core_clk,
	// Write strobes and data
	output logic voltageLimitWrite,
	output logic [15:0] voltageLimitValue,
	output logic currentLimitWrite,
	output logic [12:0] currentLimitValue,
	output logic optionWrite,
	output logic [15:0] optionWordIn
);
	// ==========================================================
	// Idle strobes; data parked on an arbitrary pattern
	initial begin
		voltageLimitWrite = 1'b0;
		currentLimitWrite = 1'b0;
		optionWrite = 1'b0;
		voltageLimitValue = 16'hA5A5;
		currentLimitValue = 13'h0A5A;
		optionWordIn = 16'h5A5A;
	end

	// Each limit write re-arms the supervisor timer; data inverted once released
	task automatic wr_v(input logic [15:0] v);
		@(negedge core_clk);
		voltageLimitValue = v;
		voltageLimitWrite = 1'b1;
		@(negedge core_clk);
		voltageLimitWrite = 1'b0;
		voltageLimitValue = ~v;
	endtask : wr_v

	task automatic wr_i(input logic [12:0] v);
		@(negedge core_clk);
		currentLimitValue = v;
		currentLimitWrite = 1'b1;
		@(negedge core_clk);
		currentLimitWrite = 1'b0;
		currentLimitValue = ~v;
	endtask : wr_i

	task automatic wr_o(input logic [15:0] v);
		@(negedge core_clk);
		optionWordIn = v;
		optionWrite = 1'b1;
		@(negedge core_clk);
		optionWrite = 1'b0;
		optionWordIn = ~v;
	endtask : wr_o
endmodule : cfsup_host

//--- bench/cfsup_chk.sv
// Port-level assertion checker for the charger fault supervisor.
`timescale 1ns/1ns
module cfsup_chk import cfsup_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Host and converter inputs
	input wire logic voltageLimitWrite,
	input wire logic [15:0] voltageLimitValue,
	input wire logic currentLimitWrite,
	input wire logic [12:0] currentLimitValue,
	input wire logic adapterPresent,
	// Outputs
	input wire logic highSideSwitch,
	input wire logic lowSideSwitch,
	input wire logic inputPowerSwitch,
	input wire logic dischargeSink,
	input wire logic [1:0] peakLimitSel,
	input wire logic [12:0] currentTarget,
	input wire logic [15:0] voltageLimitReg,
	input wire logic [12:0] currentLimitReg,
	input wire cfsup_status_t status
);
	// ==========================================================
	// One domain; reset silences every check
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Switch overlap and dead time
	chk_no_overlap: assert property (!(highSideSwitch && lowSideSwitch))
		else $error("both switches on");
	chk_hs_dead: assert property ($fell(highSideSwitch) |-> !lowSideSwitch [*3])
		else $error("low side on inside dead time");
	chk_ls_dead: assert property ($fell(lowSideSwitch) |-> !highSideSwitch [*3])
		else $error("high side on inside dead time");
	// Register copies, timer restart and peak limit band
	chk_vlim_copy: assert property (voltageLimitWrite |=>
		voltageLimitReg == $past(voltageLimitValue)) else $error("voltage copy wrong");
	chk_wd_restart: assert property (currentLimitWrite |=> !status.watchdogExpired
		&& currentLimitReg == $past(currentLimitValue)) else $error("limit write no restart");
	chk_peak_band: assert property (peakLimitSel == (currentLimitReg < PEAK_BAND1_MA ?
		PEAK_6A : (currentLimitReg < PEAK_BAND2_MA ? PEAK_9A : PEAK_12A)))
		else $error("peak limit band wrong");
	// Over-voltage sink, switch blocking, input switch and battery-low cap
	chk_sink_zero: assert property (voltageLimitReg == 16'h0000 |-> !dischargeSink)
		else $error("sink with zero limit");
	chk_sink_ovp: assert property (dischargeSink |-> status.overVoltage)
		else $error("sink outside over-voltage");
	chk_ovp_block: assert property (status.overVoltage [*2] |->
		!highSideSwitch && !lowSideSwitch) else $error("switch on in over-voltage");
	chk_therm_block: assert property (status.thermalStop [*3] |->
		!highSideSwitch && !lowSideSwitch) else $error("switch on in thermal stop");
	chk_input_drop: assert property (!adapterPresent |-> !inputPowerSwitch)
		else $error("input switch on without adapter");
	chk_bl_cap: assert property (status.batteryLow [*3] |-> currentTarget <= BATLOW_CAP_MA)
		else $error("target above battery-low cap");

	// Main scenarios reached
	cov_cycle: cover property (highSideSwitch ##[1:10] lowSideSwitch);
	cov_expiry: cover property (status.watchdogExpired);
	cov_latch: cover property ($fell(inputPowerSwitch) && adapterPresent);
	cov_sink: cover property (dischargeSink);
endmodule : cfsup_chk

bind cfsup_top cfsup_chk i_chk (.core_clk, .rst_b, .voltageLimitWrite, .voltageLimitValue,
	.currentLimitWrite, .currentLimitValue, .adapterPresent, .highSideSwitch, .lowSideSwitch,
	.inputPowerSwitch, .dischargeSink, .peakLimitSel, .currentTarget, .voltageLimitReg,
	.currentLimitReg, .status);

//--- bench/tb_top.sv
// Self-checking bench for the charger fault supervisor.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end
`define WT(c, n) for (int k = 0; k < n && !(c); k++) @(negedge core_clk);
module tb_top import cfsup_pkg::*;;
	// ==========================================================
	// Stimulus and observed signals
	logic core_clk, rst_b, cycleStart, errorAboveRamp, adapterPresent;
	cfsup_flags_t flg;
	logic voltageLimitWrite, currentLimitWrite, optionWrite;
	logic [15:0] voltageLimitValue, optionWordIn, voltageLimitReg, optionWordReg;
	logic [12:0] currentLimitValue, currentLimitReg, currentTarget;
	logic highSideSwitch, lowSideSwitch, inputPowerSwitch, dischargeSink;
	logic [1:0] peakLimitSel;
	cfsup_status_t status;
	int n_mismatch = 0;
	int n_checks = 0;

	always #5 core_clk = ~core_clk;

	// Host model and block; timers shortened so the run stays brief
	cfsup_host i_host (.core_clk, .voltageLimitWrite, .voltageLimitValue, .currentLimitWrite,
		.currentLimitValue, .optionWrite, .optionWordIn);
	cfsup_top #(.TICK_LEN(10), .WD_SHORT_LEN(20), .WD_MID_LEN(40), .WD_LONG_LEN(80),
		.SS_STEP_LEN(8)) i_dut (.core_clk, .rst_b, .voltageLimitWrite, .voltageLimitValue,
		.currentLimitWrite, .currentLimitValue, .optionWrite, .optionWordIn, .cycleStart,
		.errorAboveRamp, .adapterPresent, .flagsIn(flg), .highSideSwitch, .lowSideSwitch,
		.inputPowerSwitch, .dischargeSink, .peakLimitSel, .currentTarget, .voltageLimitReg,
		.currentLimitReg, .optionWordReg, .status);

	// ==========================================================
	// Helpers
	task tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	task lim;
		i_host.wr_v(16'h3000);
		i_host.wr_i(13'h12C);
	endtask : lim
	task pulse;
		cycleStart = 1'b1;
		@(negedge core_clk);
		cycleStart = 1'b0;
	endtask : pulse

	// ==========================================================
	// Scenarios
	task t_soft;
		logic [12:0] q[$];
		logic [12:0] last;
		last = 13'h000;
		lim;
		repeat (80) begin
			@(negedge core_clk);
			if (currentTarget !== last) begin
				q.push_back(currentTarget);
				last = currentTarget;
			end
		end
		`CHK("ss first", SS_START_MA, q[0])
		`CHK("ss step", SS_START_MA + SS_STEP_MA, q[1])
		`CHK("ss end", 13'h12C, q[3])
	endtask : t_soft

	task t_switch;
		lim;
		errorAboveRamp = 1'b1;
		pulse;
		`WT(highSideSwitch, 10)
		`CHK("hs on", 1'b1, highSideSwitch)
		errorAboveRamp = 1'b0;
		`WT(lowSideSwitch, 10)
		`CHK("ls on", 1'b1, lowSideSwitch)
		flg.underCurrent = 1'b1;
		`WT(!lowSideSwitch, 6)
		`CHK("ls ucp", 1'b0, lowSideSwitch)
		flg.underCurrent = 1'b0;
		errorAboveRamp = 1'b1;
		pulse;
		`WT(highSideSwitch, 10)
		flg.peakOverCurrent = 1'b1;
		`WT(!highSideSwitch, 6)
		`CHK("hs peak", 1'b0, highSideSwitch)
		flg.peakOverCurrent = 1'b0;
		tick(12);
		`CHK("hs held", 1'b0, highSideSwitch)
		pulse;
		`WT(highSideSwitch, 10)
		`CHK("hs next", 1'b1, highSideSwitch)
		errorAboveRamp = 1'b0;
		tick(20);
	endtask : t_switch

	task t_nonsync;
		lim;
		flg.avgCurrentLow = 1'b1;
		`WT(status.nonSync, 6)
		`CHK("nonsync", 1'b1, status.nonSync)
		errorAboveRamp = 1'b1;
		pulse;
		`WT(highSideSwitch, 10)
		flg.bootstrapLow = 1'b1;
		`WT(lowSideSwitch, 12)
		`CHK("refresh", 1'b1, lowSideSwitch)
		flg.bootstrapLow = 1'b0;
		errorAboveRamp = 1'b0;
		tick(20);
		`CHK("ls async", 1'b0, lowSideSwitch)
		flg.avgCurrentLow = 1'b0;
		flg.avgCurrentHigh = 1'b1;
		`WT(!status.nonSync, 6)
		`CHK("sync", 1'b0, status.nonSync)
		flg.avgCurrentHigh = 1'b0;
	endtask : t_nonsync

	task t_protect;
		i_host.wr_i(13'h07D0);
		flg.dieHot = 1'b1;
		flg.dieCool = 1'b0;
		`WT(status.thermalStop, 6)
		flg.dieHot = 1'b0;
		tick(10);
		`CHK("therm hyst", 1'b1, status.thermalStop)
		flg.dieCool = 1'b1;
		`WT(!status.thermalStop, 6)
		`CHK("therm off", 1'b0, status.thermalStop)
		tick(60);
		flg.batLow = 1'b1;
		`WT(status.batteryLow, 6)
		`CHK("bat low", 1'b1, status.batteryLow)
		tick(4);
		`CHK("bl cap", BATLOW_CAP_MA, currentTarget)
		tick(110);
		`CHK("bl reset", 1'b0, status.charging)
		flg.batLow = 1'b0;
		tick(450);
		`CHK("bl restart", 1'b1, status.charging)
	endtask : t_protect

	task t_input_overcurrent_latch;
		lim;
		flg.sysOverCurrent = 1'b1;
		tick(380);
		`CHK("blank", 1'b1, inputPowerSwitch)
		tick(80);
		`CHK("latched", 1'b0, inputPowerSwitch)
		flg.sysOverCurrent = 1'b0;
		tick(5);
		`CHK("stays", 1'b0, inputPowerSwitch)
		adapterPresent = 1'b0;
		tick(4);
		adapterPresent = 1'b1;
		tick(4);
		`CHK("cleared", 1'b1, inputPowerSwitch)
		i_host.wr_o(16'h6000);
		flg.sysOverCurrent = 1'b1;
		tick(500);
		`CHK("no latch", 1'b1, inputPowerSwitch)
		flg.sysOverCurrent = 1'b0;
		i_host.wr_o(16'h6002);
	endtask : t_input_overcurrent_latch

	task t_ovp;
		lim;
		flg.batOverVoltage = 1'b1;
		tick(4);
		`CHK("sink", 1'b1, dischargeSink)
		tick(3100);
		`CHK("ovp off", 1'b1, status.overVoltageOff)
		flg.batOverVoltage = 1'b0;
		tick(4);
		`CHK("sink off", 1'b0, dischargeSink)
		`CHK("off held", 1'b1, status.overVoltageOff)
		adapterPresent = 1'b0;
		tick(4);
		adapterPresent = 1'b1;
		`CHK("off clear", 1'b0, status.overVoltageOff)
		i_host.wr_v(16'h0000);
		flg.batOverVoltage = 1'b1;
		tick(4);
		`CHK("zero lim", 1'b0, dischargeSink)
		flg.batOverVoltage = 1'b0;
	endtask : t_ovp

	task t_peak;
		logic [12:0] cv[4];
		logic [1:0] ex[4];
		cv = '{PEAK_BAND1_MA - 13'h001, PEAK_BAND1_MA, PEAK_BAND2_MA - 13'h001, PEAK_BAND2_MA};
		ex = '{PEAK_6A, PEAK_9A, PEAK_9A, PEAK_12A};
		foreach (cv[i]) begin
			i_host.wr_i(cv[i]);
			`CHK("peak sel", ex[i], peakLimitSel)
		end
	endtask : t_peak

	task t_wdog;
		for (int c = 1; c < 4; c++) begin
			i_host.wr_o({1'b0, c[1:0], 13'h0002});
			lim;
			tick((200 << (c - 1)) - 30);
			`CHK("wd early", 1'b0, status.watchdogExpired)
			tick(70);
			`CHK("wd expire", 1'b1, status.watchdogExpired)
		end
		`CHK("no charge", 1'b0, status.charging)
		`CHK("vlim kept", 16'h3000, voltageLimitReg)
		`CHK("opt kept", 16'h6002, optionWordReg)
		i_host.wr_v(16'h3000);
		`CHK("wd restart", 1'b0, status.watchdogExpired)
		tick(830);
		`CHK("wd again", 1'b1, status.watchdogExpired)
		i_host.wr_o(16'h0002);
		`CHK("wd off", 1'b0, status.watchdogExpired)
		tick(2);
		`CHK("wd resume", 1'b1, status.charging)
	endtask : t_wdog

	// ==========================================================
	// Verdict, main sequence and hang guard
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		cycleStart = 1'b0;
		errorAboveRamp = 1'b0;
		adapterPresent = 1'b1;
		flg = 10'h002; // Only the cool flag up at start
		tick(20);
		rst_b = 1'b1;
		`CHK("opt reset", OPT_RESET, optionWordReg)
		t_soft;
		t_switch;
		t_nonsync;
		t_protect;
		t_input_overcurrent_latch;
		t_ovp;
		t_peak;
		t_wdog;
		give_verdict;
	end

	// Whole run is near 7300 cycles; cut off well beyond that
	initial begin
		#300000;
		n_mismatch++;
		give_verdict;
	end
endmodule : tb_top
